/* File: src/fcp_pkg.sv */
// Package for the flash command and protection host controller.
package fcp_pkg;
  // Register offsets of the controller's own register file.
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_ADDR   = 4'h1;
  localparam logic [3:0] REG_WDATA  = 4'h2;
  localparam logic [3:0] REG_RDATA  = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_TIMING = 4'h5;
  // Fields of the control register.
  localparam int CTRL_GO_BIT    = 0;
  localparam int CTRL_WRITE_BIT = 1;
  localparam int CTRL_HVID_BIT  = 2;
  localparam int CTRL_HVRST_BIT = 3;
  localparam int CTRL_CMD_LSB   = 4;
  // Command codes issued through the control register.
  localparam logic [2:0] CMD_RAW      = 3'h0;
  localparam logic [2:0] CMD_RESET    = 3'h1;
  localparam logic [2:0] CMD_AUTOSEL  = 3'h2;
  localparam logic [2:0] CMD_PROGRAM  = 3'h3;
  localparam logic [2:0] CMD_HV_ID    = 3'h4;
  // Unlock and command addresses and data of the command set.
  localparam logic [19:0] UNLOCK_ADDR1 = 20'h00555;
  localparam logic [19:0] UNLOCK_ADDR2 = 20'h002aa;
  localparam logic [15:0] UNLOCK_DATA1 = 16'h00aa;
  localparam logic [15:0] UNLOCK_DATA2 = 16'h0055;
  localparam logic [15:0] RESET_DATA   = 16'h00f0;
  localparam logic [15:0] AUTOSEL_DATA = 16'h0090;
  localparam logic [15:0] PROGRAM_DATA = 16'h00a0;
  // Identification selector codes on the low address bits.
  localparam logic [1:0] ID_SEL_MANUF  = 2'h0;
  localparam logic [1:0] ID_SEL_DEVICE = 2'h1;
  localparam logic [1:0] ID_SEL_PROT   = 2'h2;
  // Strobe timing: phases must exceed the glitch filter width.
  localparam int GLITCH_NS     = 5;
  localparam int CLK_NS        = 10;
  localparam int GLITCH_CYC    = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] PHASE_RESET = 8'h04;
  // Reset values.
  localparam logic [15:0] ZERO16 = 16'h0000;
endpackage : fcp_pkg

/* File: src/fcp_bus_if.sv */
// Interface carrying one flash bus cycle request between sequencer and pin driver.
interface fcp_bus_if;
  logic        req;
  logic        is_write;
  logic [19:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        done;
  modport seq (output req, output is_write, output addr, output wdata, input rdata, input done);
  modport drv (input req, input is_write, input addr, input wdata, output rdata, output done);
endinterface : fcp_bus_if

/* File: src/fcp_pin_drv.sv */
// Pin driver performing one timed read or write cycle on the flash pins.
module fcp_pin_drv
  import fcp_pkg::*;
(
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        reset,
  // Request side.
  fcp_bus_if.drv           bus,
  input  wire logic [7:0]  phase_cycles,
  // Flash pins.
  output logic             chip_sel_n,
  output logic             wr_strobe_n,
  output logic             out_drive_n,
  output logic [19:0]      flash_addr,
  output logic [15:0]      data_out,
  output logic             data_oe_n,
  input  wire logic [15:0] data_in
);
  typedef enum {FCP_IDLE, FCP_SETUP, FCP_ACTIVE, FCP_HOLD} fcp_drv_t;
  fcp_drv_t    state, next_state;
  logic [7:0]  cnt, next_cnt;
  logic        next_cs_n, next_we_n, next_oe_n, next_doe_n, next_done;
  logic [19:0] next_addr;
  logic [15:0] next_dout, rdata_q, next_rdata;
  logic [7:0]  min_phase;

  // Phase length never drops under the glitch filter width.
  assign min_phase = (phase_cycles < 8'(GLITCH_CYC + 1)) ? 8'(GLITCH_CYC + 1) : phase_cycles;
  assign bus.rdata = rdata_q;

  // Next-state logic of one bus cycle.
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_cs_n  = chip_sel_n;
    next_we_n  = wr_strobe_n;
    next_oe_n  = out_drive_n;
    next_doe_n = data_oe_n;
    next_addr  = flash_addr;
    next_dout  = data_out;
    next_rdata = rdata_q;
    next_done  = 1'b0;
    case (state)
      FCP_IDLE: begin
        if (bus.req) begin
          // Output drive goes high first so a write is never mistaken for a read. [RULE14]
          next_oe_n  = 1'b1;
          next_addr  = bus.addr;
          next_dout  = bus.wdata;
          next_doe_n = !bus.is_write;
          next_cnt   = min_phase;
          next_state = FCP_SETUP;
        end
      end
      FCP_SETUP: begin
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h01) begin
          // Address is stable before the later falling edge. [RULE17]
          next_cs_n = 1'b0;
          if (bus.is_write) next_we_n = 1'b0; // [RULE14]
          else next_oe_n = 1'b0;
          next_cnt   = min_phase;
          next_state = FCP_ACTIVE;
        end
      end
      FCP_ACTIVE: begin
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h01) begin
          // Write strobe rises first, with data still held, so data is taken there. [RULE18] [RULE13]
          next_we_n  = 1'b1;
          next_rdata = data_in;
          next_oe_n  = 1'b1;
          next_cnt   = min_phase;
          next_state = FCP_HOLD;
        end
      end
      FCP_HOLD: begin
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h01) begin
          next_cs_n  = 1'b1;
          next_doe_n = 1'b1;
          next_done  = 1'b1;
          next_state = FCP_IDLE;
        end
      end
      default: next_state = FCP_IDLE;
    endcase
  end

  // Registers of the pin driver; pins are idle-inhibited after reset.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state       <= FCP_IDLE;
      cnt         <= 8'h00;
      chip_sel_n  <= 1'b1;
      wr_strobe_n <= 1'b1;
      out_drive_n <= 1'b1;
      data_oe_n   <= 1'b1;
      flash_addr  <= 20'h00000;
      data_out    <= ZERO16;
      rdata_q     <= ZERO16;
      bus.done    <= 1'b0;
    end else begin
      state       <= next_state;
      cnt         <= next_cnt;
      chip_sel_n  <= next_cs_n;
      wr_strobe_n <= next_we_n;
      out_drive_n <= next_oe_n;
      data_oe_n   <= next_doe_n;
      flash_addr  <= next_addr;
      data_out    <= next_dout;
      rdata_q     <= next_rdata;
      bus.done    <= next_done;
    end
  end
endmodule : fcp_pin_drv

/* File: src/fcp_host.sv */
// Host controller that drives a parallel NOR flash through its command and protection pins.
// Operation
// (RULE1) Device puts identifier values on low data byte in identification mode.
// (RULE2) High-voltage identification needs the high level on the id pin; host applies it.
// (RULE3) Selector pins all low manufacturer, low-low-high device, low-high-low protection.
// (RULE4) Protection query returns 00h unprotected, low bit one when protected.
// (RULE5) Host can enter identification by command, no high voltage needed.
// (RULE6) Protected sectors reject program and erase until unprotected.
// (RULE7) Permanent protection changes need external equipment with high voltage.
// (RULE8) Sectors leave manufacture unprotected unless factory protection was ordered.
// (RULE9) High level on reset pin temporarily unprotects all sectors.
// (RULE10) Removing that level restores earlier protection.
// (RULE11) Program and erase need unlock writes before the command.
// (RULE12) Below lockout supply all writes are ignored and device resets.
// (RULE13) Strobe pulses under 5 ns never start a write.
// (RULE14) Write needs chip select and write strobe low, output drive high.
// (RULE15) Strobes low during power-up give no command on strobe rise.
// (RULE16) Wrong address, data or order returns to array read.
// (RULE17) Address taken at the later falling edge of strobe or select.
// (RULE18) Data taken at the first rising edge of strobe or select.
// (RULE19) Array read after power-up and after program or erase completes.
// (RULE20) Erase suspend reads give status inside suspended sectors, array elsewhere.
// (RULE21) Host writes reset to leave identification or after timeout flag.
// (RULE22) Command identification: offset 00h manufacturer, 01h device, 02h protection.
// (RULE23) Reset command ignores address and is ignored once an operation runs.
// (RULE24) Each high-voltage detection is a separate digital qualifier.
module fcp_host
  import fcp_pkg::*;
#(
  parameter int SECT_BITS = 7
) (
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        reset,
  // Software register port.
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic [31:0]      reg_rdata,
  // Flash strobes and address.
  output logic             chip_sel_n,
  output logic             wr_strobe_n,
  output logic             out_drive_n,
  output logic [19:0]      flash_addr,
  // Flash data pins.
  output logic [15:0]      data_out,
  output logic             data_oe_n,
  input  wire logic [15:0] data_in,
  // High-voltage qualifiers applied to the flash.
  output logic             id_voltage_pin,
  output logic             reset_hv
);
  typedef enum {FCP_S_IDLE, FCP_S_CYC, FCP_S_WAIT} fcp_seq_t;

  fcp_bus_if bus ();

  fcp_seq_t    state, next_state;
  logic [2:0]  cmd, next_cmd;
  logic [1:0]  step, next_step, last_step;
  logic        raw_write, next_raw_write;
  logic [19:0] op_addr, next_op_addr;
  logic [15:0] op_wdata, next_op_wdata;
  logic [15:0] rd_data, next_rd_data;
  logic        busy, next_busy;
  logic        done_flag, next_done_flag;
  logic        hv_id, next_hv_id;
  logic        hv_rst, next_hv_rst;
  logic [7:0]  phase, next_phase;
  logic [31:0] next_reg_rdata;
  logic        go;

  // Cycle address of a given step of a command sequence.
  function automatic logic [19:0] step_addr(input logic [2:0] c, input logic [1:0] s, input logic [19:0] a);
    if (c == CMD_RAW || c == CMD_HV_ID) step_addr = a; // Selector pins come from the address register. [RULE3]
    else if (c == CMD_RESET) step_addr = a; // Address does not matter. [RULE23]
    else if (s == 2'd0) step_addr = UNLOCK_ADDR1;
    else if (s == 2'd1) step_addr = UNLOCK_ADDR2;
    else if (s == 2'd2) step_addr = UNLOCK_ADDR1;
    else step_addr = a;
  endfunction : step_addr

  // Cycle data of a given step of a command sequence.
  function automatic logic [15:0] step_data(input logic [2:0] c, input logic [1:0] s, input logic [15:0] d);
    if (c == CMD_RAW) step_data = d;
    else if (c == CMD_RESET) step_data = RESET_DATA; // [RULE21]
    else if (s == 2'd0) step_data = UNLOCK_DATA1;
    else if (s == 2'd1) step_data = UNLOCK_DATA2;
    else if (c == CMD_AUTOSEL) step_data = AUTOSEL_DATA; // [RULE5]
    else if (s == 2'd2) step_data = PROGRAM_DATA;
    else step_data = d;
  endfunction : step_data

  fcp_pin_drv u_drv (
    .core_clk     (core_clk),
    .reset        (reset),
    .bus          (bus.drv),
    .phase_cycles (phase),
    .chip_sel_n   (chip_sel_n),
    .wr_strobe_n  (wr_strobe_n),
    .out_drive_n  (out_drive_n),
    .flash_addr   (flash_addr),
    .data_out     (data_out),
    .data_oe_n    (data_oe_n),
    .data_in      (data_in)
  );

  assign go = reg_write && (reg_addr == REG_CTRL) && reg_wdata[CTRL_GO_BIT] && !busy;

  // Number of the last cycle in each command sequence; unlocks precede program. [RULE11]
  always_comb begin
    case (cmd)
      CMD_AUTOSEL: last_step = 2'd2;
      CMD_PROGRAM: last_step = 2'd3;
      default:     last_step = 2'd0;
    endcase
  end

  // Bus request toward the pin driver.
  assign bus.req      = (state == FCP_S_CYC);
  assign bus.is_write = (cmd == CMD_RAW) ? raw_write : (cmd != CMD_HV_ID);
  assign bus.addr     = step_addr(cmd, step, op_addr);
  assign bus.wdata    = step_data(cmd, step, op_wdata);

  // Sequencer and register file next values.
  always_comb begin
    next_state     = state;
    next_cmd       = cmd;
    next_step      = step;
    next_raw_write = raw_write;
    next_op_addr   = op_addr;
    next_op_wdata  = op_wdata;
    next_rd_data   = rd_data;
    next_busy      = busy;
    next_done_flag = done_flag;
    next_hv_id     = hv_id;
    next_hv_rst    = hv_rst;
    next_phase     = phase;
    if (reg_write) begin
      case (reg_addr)
        REG_CTRL: begin
          // Separate qualifiers for the two high-voltage detections. [RULE24] [RULE2] [RULE7]
          next_hv_id  = reg_wdata[CTRL_HVID_BIT];
          // Held high for temporary unprotect, released to reprotect. [RULE9] [RULE10]
          next_hv_rst = reg_wdata[CTRL_HVRST_BIT];
          if (go) begin
            next_cmd       = reg_wdata[CTRL_CMD_LSB +: 3];
            next_raw_write = reg_wdata[CTRL_WRITE_BIT];
            next_step      = 2'd0;
            next_busy      = 1'b1;
            next_done_flag = 1'b0;
            next_state     = FCP_S_CYC;
          end
        end
        REG_ADDR:   if (!busy) next_op_addr = reg_wdata[19:0];
        REG_WDATA:  if (!busy) next_op_wdata = reg_wdata[15:0];
        REG_TIMING: next_phase = reg_wdata[7:0];
        default: ;
      endcase
    end
    case (state)
      FCP_S_IDLE: ;
      FCP_S_CYC:  next_state = FCP_S_WAIT;
      FCP_S_WAIT: begin
        if (bus.done) begin
          if (step == last_step) begin
            // Low byte carries identifier or protection bit on reads. [RULE1] [RULE4] [RULE22]
            next_rd_data   = bus.rdata;
            next_busy      = 1'b0;
            next_done_flag = 1'b1;
            next_state     = FCP_S_IDLE;
          end else begin
            next_step  = step + 2'd1;
            next_state = FCP_S_CYC;
          end
        end
      end
      default: next_state = FCP_S_IDLE;
    endcase
  end

  // Read data appears one cycle after the read strobe.
  always_comb begin
    next_reg_rdata = 32'h00000000;
    if (reg_read) begin
      case (reg_addr)
        REG_CTRL:   next_reg_rdata = {28'h0000000, hv_rst, hv_id, 2'b00};
        REG_ADDR:   next_reg_rdata = {12'h000, op_addr};
        REG_WDATA:  next_reg_rdata = {16'h0000, op_wdata};
        REG_RDATA:  next_reg_rdata = {16'h0000, rd_data};
        REG_STATUS: next_reg_rdata = {30'h00000000, done_flag, busy};
        REG_TIMING: next_reg_rdata = {24'h000000, phase};
        default:    next_reg_rdata = 32'h00000000;
      endcase
    end
  end

  // Registers; reset leaves the flash in array read with no qualifiers applied. [RULE19]
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state          <= FCP_S_IDLE;
      cmd            <= CMD_RAW;
      step           <= 2'd0;
      raw_write      <= 1'b0;
      op_addr        <= 20'h00000;
      op_wdata       <= ZERO16;
      rd_data        <= ZERO16;
      busy           <= 1'b0;
      done_flag      <= 1'b0;
      hv_id          <= 1'b0;
      hv_rst         <= 1'b0;
      phase          <= PHASE_RESET;
      reg_rdata      <= 32'h00000000;
      id_voltage_pin <= 1'b0;
      reset_hv       <= 1'b0;
    end else begin
      state          <= next_state;
      cmd            <= next_cmd;
      step           <= next_step;
      raw_write      <= next_raw_write;
      op_addr        <= next_op_addr;
      op_wdata       <= next_op_wdata;
      rd_data        <= next_rd_data;
      busy           <= next_busy;
      done_flag      <= next_done_flag;
      hv_id          <= next_hv_id;
      hv_rst         <= next_hv_rst;
      phase          <= next_phase;
      reg_rdata      <= next_reg_rdata;
      id_voltage_pin <= next_hv_id;
      reset_hv       <= next_hv_rst;
    end
  end
endmodule : fcp_host

/* File: dv/fcp_host_monitor.sv */
// Checker for the host controller's flash pins.
module fcp_host_monitor (
  // Clock and reset.
  input wire logic        core_clk,
  input wire logic        reset,
  // Flash pins.
  input wire logic        chip_sel_n,
  input wire logic        wr_strobe_n,
  input wire logic        out_drive_n,
  input wire logic [19:0] flash_addr,
  input wire logic [15:0] data_out,
  input wire logic        data_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // Select must outlast the write strobe so the strobe edge is what latches data.
  sequence s_cs_hold;
    !chip_sel_n ##1 !chip_sel_n;
  endsequence
  sequence s_addr_held;
    $stable(flash_addr) ##1 $stable(flash_addr);
  endsequence
  property p_idle;
    $past(reset) |-> chip_sel_n && wr_strobe_n && out_drive_n && data_oe_n;
  endproperty
  property p_no_wr_rd;
    !(!wr_strobe_n && !out_drive_n);
  endproperty
  property p_we_cs;
    !wr_strobe_n |-> !chip_sel_n;
  endproperty
  property p_we_width;
    $fell(wr_strobe_n) |=> !wr_strobe_n;
  endproperty
  property p_oe_width;
    $fell(out_drive_n) |=> !out_drive_n;
  endproperty
  property p_addr;
    $fell(wr_strobe_n) |-> s_addr_held;
  endproperty
  property p_data;
    $rose(wr_strobe_n) |-> !data_oe_n && $stable(data_out);
  endproperty
  property p_cs_hold;
    $rose(wr_strobe_n) |-> s_cs_hold;
  endproperty
  property p_bus_free;
    !out_drive_n |-> data_oe_n;
  endproperty
  a_idle: assert property (p_idle) else $error("Strobes not idle after reset");
  a_no_wr_rd: assert property (p_no_wr_rd) else $error("Write and output strobes low together");
  a_we_cs: assert property (p_we_cs) else $error("Write strobe low without select");
  a_we_width: assert property (p_we_width) else $error("Write strobe pulse too short");
  a_oe_width: assert property (p_oe_width) else $error("Output strobe pulse too short");
  a_addr: assert property (p_addr) else $error("Address moved at write strobe fall");
  a_data: assert property (p_data) else $error("Write data not held at strobe rise");
  a_cs_hold: assert property (p_cs_hold) else $error("Select released with write strobe");
  a_bus_free: assert property (p_bus_free) else $error("Host drives data during read");
endmodule : fcp_host_monitor

/* File: dv/fcp_flash_model.sv */
// Behavioural flash device answering the host controller's bus cycles.
module fcp_flash_model #(
  parameter logic [7:0] MANUF_CODE = 8'h3c, // Arbitrary value.
  parameter logic [7:0] DEV_CODE   = 8'h4b, // Arbitrary value.
  parameter int         PROT_SECT  = 5
) (
  // Strobes and address.
  input  wire logic        chip_sel_n,
  input  wire logic        wr_strobe_n,
  input  wire logic        out_drive_n,
  input  wire logic [19:0] flash_addr,
  // Data.
  input  wire logic [15:0] data_out,
  output logic [15:0]      data_in,
  // High-voltage qualifiers.
  input  wire logic        id_voltage_pin,
  input  wire logic        reset_hv
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [int];
  logic [19:0] lat_a;
  logic [15:0] last = 16'h0000, val;
  logic        armed = 1'b0, auto_sel = 1'b0;
  int          st = 0;
  realtime     t0;
  function automatic logic [15:0] id_val(input logic [2:0] s, input logic [19:0] ad);
    case (s)
      3'h0: return {8'h00, MANUF_CODE};
      3'h1: return {8'h00, DEV_CODE};
      3'h2: return {15'h0, ad[18:12] == PROT_SECT[6:0]};
      default: return 16'h0000;
    endcase
  endfunction : id_val
  function automatic logic [15:0] arr(input logic [19:0] ad);
    return mem.exists(ad) ? mem[ad] : 16'hffff;
  endfunction : arr
  task automatic cmd_write(input logic [19:0] ad, input logic [15:0] d);
    if (d == 16'h00f0 && st != 3) begin
      st = 0;
      auto_sel = 1'b0;
    end else case (st)
      0: st = (ad[10:0] == 11'h555 && d == 16'h00aa) ? 1 : 0;
      1: st = (ad[10:0] == 11'h2aa && d == 16'h0055) ? 2 : 0;
      2: begin
        auto_sel = auto_sel | (ad[10:0] == 11'h555 && d == 16'h0090);
        st = (ad[10:0] == 11'h555 && d == 16'h00a0) ? 3 : 0;
      end
      default: begin
        if (ad[18:12] != PROT_SECT[6:0] || reset_hv) mem[ad] = arr(ad) & d;
        st = 0;
      end
    endcase
  endtask : cmd_write
  // Read answers; a released bus shows the inverse of its last value, never a stale copy.
  always @(chip_sel_n, out_drive_n, flash_addr, id_voltage_pin) begin
    if (!chip_sel_n && !out_drive_n) begin
      val = id_voltage_pin ? id_val({flash_addr[6], flash_addr[1:0]}, flash_addr)
          : auto_sel ? id_val({1'b0, flash_addr[1:0]}, flash_addr) : arr(flash_addr);
      last = val;
      data_in = val;
    end else data_in = ~last;
  end
  // Address taken at the later falling edge; an output strobe low forbids the write.
  always @(negedge chip_sel_n or negedge wr_strobe_n) begin
    if (!chip_sel_n && !wr_strobe_n && out_drive_n) begin
      lat_a = flash_addr;
      armed = 1'b1;
      t0 = $realtime;
    end
  end
  // Data taken at the first rising edge; glitches under 5 ns are dropped.
  always @(posedge chip_sel_n or posedge wr_strobe_n) begin
    if (armed && $realtime - t0 >= 5.0) cmd_write(lat_a, data_out);
    armed = 1'b0;
  end
endmodule : fcp_flash_model

/* File: dv/fcp_host_tb.sv */
// Self-checking testbench for the flash command and protection host controller.
module fcp_host_tb
  import fcp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int         PS = 5;
  localparam logic [7:0] MC = 8'h3c; // Arbitrary value.
  localparam logic [7:0] DC = 8'h4b; // Arbitrary value.
  logic        core_clk = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0, hv = 1'b0, hr = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, v, rng = 32'h08d0e3cd;
  logic [19:0] flash_addr, a;
  logic [15:0] data_out, data_in;
  logic        chip_sel_n, wr_strobe_n, out_drive_n, data_oe_n, id_voltage_pin, reset_hv;
  logic [15:0] em [int];
  int          fails = 0, n_compared = 0;
  always #5 core_clk = ~core_clk;
  fcp_host dut (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .chip_sel_n(chip_sel_n),
    .wr_strobe_n(wr_strobe_n), .out_drive_n(out_drive_n), .flash_addr(flash_addr), .data_out(data_out),
    .data_oe_n(data_oe_n), .data_in(data_in), .id_voltage_pin(id_voltage_pin), .reset_hv(reset_hv));
  fcp_flash_model #(.MANUF_CODE(MC), .DEV_CODE(DC), .PROT_SECT(PS)) u_flash (.chip_sel_n(chip_sel_n),
    .wr_strobe_n(wr_strobe_n), .out_drive_n(out_drive_n), .flash_addr(flash_addr), .data_out(data_out),
    .data_in(data_in), .id_voltage_pin(id_voltage_pin), .reset_hv(reset_hv));
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : rnd
  function automatic logic [15:0] ev(input logic [19:0] ad);
    return em.exists(ad) ? em[ad] : 16'hffff;
  endfunction : ev
  task automatic wrap_up();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  task automatic check(input logic [31:0] got, input logic [31:0] ex);
    n_compared++;
    if (got !== ex) begin
      $display("Error at %0t: got %h expected %h", $time, got, ex);
      fails++;
    end
  endtask : check
  // Register write; a spare edge keeps the strobe from being driven twice in one step.
  task automatic wr(input logic [3:0] ad, input logic [31:0] dt);
    reg_addr <= ad;
    reg_wdata <= dt;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [3:0] ad);
    reg_addr <= ad;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
    @(posedge core_clk);
  endtask : rd
  // Start a sequence and poll for done under a bound.
  task automatic go(input logic [2:0] cmd, input logic w);
    wr(REG_CTRL, {25'h0, cmd, hr, hv, w, 1'b1});
    for (int i = 0; i < 400; i++) begin
      rd(REG_STATUS);
      if (v[1:0] === 2'b10) return;
    end
    fails++;
    wrap_up();
  endtask : go
  // Flash write; the reference model applies protection as the device would.
  task automatic fwr(input logic [19:0] ad, input logic [15:0] dt, input logic [2:0] cmd);
    wr(REG_ADDR, {12'h0, ad});
    wr(REG_WDATA, {16'h0, dt});
    go(cmd, 1'b1);
    if (cmd == CMD_PROGRAM && (ad[18:12] != PS || hr)) em[ad] = ev(ad) & dt;
  endtask : fwr
  task automatic fread(input logic [19:0] ad, input logic [2:0] cmd, input logic [15:0] ex);
    wr(REG_ADDR, {12'h0, ad});
    go(cmd, 1'b0);
    rd(REG_RDATA);
    check(v, {16'h0, ex});
  endtask : fread
  initial begin
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    rd(REG_STATUS);
    check(v, 32'h0);
    rd(REG_TIMING);
    check(v, {24'h0, PHASE_RESET});
    rd(4'hf);
    check(v, 32'h0);
    fread(20'h01234, CMD_RAW, 16'hffff);
    $display("Test reset done");
    // Program across strobe phase settings, down to the floor.
    for (int i = 0; i < 4; i++) begin
      wr(REG_TIMING, 32'(i * 2 + 1));
      v = rnd();
      a = {1'b0, 7'(i), v[11:0]};
      fwr(a, v[31:16], CMD_PROGRAM);
      fread(a, CMD_RAW, ev(a));
    end
    wr(REG_TIMING, 32'h4);
    $display("Test program done");
    go(CMD_AUTOSEL, 1'b0);
    fread(20'h00000, CMD_RAW, {8'h0, MC});
    fread(20'h00001, CMD_RAW, {8'h0, DC});
    fread({1'b0, 7'(PS), 12'h002}, CMD_RAW, 16'h0001);
    fread(20'h03002, CMD_RAW, 16'h0000);
    go(CMD_RESET, 1'b1);
    fread(a, CMD_RAW, ev(a));
    $display("Test autoselect done");
    a = {1'b0, 7'(PS), 12'h345};
    fwr(a, 16'h1234, CMD_PROGRAM);
    fread(a, CMD_RAW, ev(a));
    hr = 1'b1;
    fwr(a, 16'h1234, CMD_PROGRAM);
    fread(a, CMD_RAW, ev(a));
    hr = 1'b0;
    fwr(a, 16'h0004, CMD_PROGRAM);
    fread(a, CMD_RAW, ev(a));
    $display("Test protection done");
    // Address and start written while a cycle runs must both be refused.
    wr(REG_ADDR, {12'h0, a});
    wr(REG_CTRL, {25'h0, CMD_RAW, 4'h1});
    wr(REG_ADDR, 32'h0);
    go(CMD_RAW, 1'b0);
    rd(REG_RDATA);
    check(v, {16'h0, ev(a)});
    rd(REG_ADDR);
    check(v, {12'h0, a});
    $display("Test busy refusal done");
    hv = 1'b1;
    wr(REG_CTRL, {28'h0, hr, hv, 2'b00});
    rd(REG_CTRL);
    check(v, 32'h4);
    fread(20'h00000, CMD_HV_ID, {8'h0, MC});
    fread(20'h00001, CMD_HV_ID, {8'h0, DC});
    fread({1'b0, 7'(PS), 12'h002}, CMD_HV_ID, 16'h0001);
    fread(20'h00002, CMD_HV_ID, 16'h0000);
    hv = 1'b0;
    $display("Test high-voltage identification done");
    // A mid-run reset must drop the qualifier, the done flag and the timing.
    wr(REG_TIMING, 32'h9);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    rd(REG_STATUS);
    check(v, 32'h0);
    rd(REG_CTRL);
    check(v, 32'h0);
    rd(REG_TIMING);
    check(v, {24'h0, PHASE_RESET});
    $display("Test mid-run reset done");
    // A broken unlock must leave the following data write harmless.
    a = {1'b0, 7'h02, 12'h777};
    fwr(20'h00555, 16'h00aa, CMD_RAW);
    fwr(20'h002aa, 16'h0066, CMD_RAW);
    fwr(20'h00555, 16'h00a0, CMD_RAW);
    fwr(a, 16'h0000, CMD_RAW);
    fread(a, CMD_RAW, ev(a));
    $display("Test bad sequence done");
    wrap_up();
  end
endmodule : fcp_host_tb

bind fcp_host fcp_host_monitor u_mon (.core_clk(core_clk), .reset(reset), .chip_sel_n(chip_sel_n),
  .wr_strobe_n(wr_strobe_n), .out_drive_n(out_drive_n), .flash_addr(flash_addr), .data_out(data_out),
  .data_oe_n(data_oe_n));
